// ---- pkg/pisr_map.svh ----
// Register offsets, field positions and reset values of the status bank
`ifndef PISR_MAP_SVH
`define PISR_MAP_SVH
`define PISR_ADDR_INT_CS      5'h1B
`define PISR_ADDR_DIAG_CS     5'h1D
`define PISR_ADDR_PHY_CS      5'h1E
`define PISR_ADDR_PHY_CTL2    5'h1F
`define PISR_INT_EN_SHIFT     8
`define PISR_DIAG_EN_BIT      15
`define PISR_PHY_ISO_BIT      3
`define PISR_CTL2_INTLVL_BIT  9
`define PISR_DIAG_RSV_RST     3'h0
`define PISR_RESULT_RST       2'h0
`define PISR_OPMODE_RST       3'h0
`define PISR_FAULT_CNT_RST    9'h000
`endif

// ---- pkg/pisr_pkg.sv ----
// Types shared by the status register bank
package pisr_pkg;
  typedef struct packed {
    logic pd_fault;
    logic lp_ack;
    logic link_down;
    logic rem_fault;
    logic link_up;
  } pisr_events_t;

  typedef struct packed {
    logic       done;
    logic [1:0] result;
    logic       short_cable;
    logic [8:0] fault_dist;
  } pisr_diag_t;

  typedef struct packed {
    logic       pause_cap;
    logic       link_up;
    logic       pol_rev;
    logic       mdix;
    logic       energy;
    logic [2:0] op_mode;
  } pisr_phy_t;
endpackage

// ---- rtl/pisr_regs.sv ----
// Interrupt, cable diagnostic and PHY status/control register slice
`timescale 1ns/1ps
`include "pisr_map.svh"
// Overview of operation
// R1: Flag bit 4 on parallel detect fault
// R2: Flag bit 3 on partner acknowledge
// R3: Flag bit 2 when link goes down
// R4: Flag bit 1 on remote fault
// R5: Flag bit 0 when link comes up
// R6: Test enable bit 15 self-clears when done
// R7: Results valid whenever test enable reads zero
// R8: Two-bit diagnostic result at bits 14:13
// R9: Short cable bit 12, distance bits 8:0
// R10: Pause capability read-only at bit 9
// R11: Link bit 8, energy detect bit 4
// R12: Polarity bit 7, crossover bit 5
// R13: Writable isolate bit 3, default zero
// R14: Resolved speed/duplex code at bits 2:0
// R15: Enables eight above flags gate interrupt
// R16: Interrupt level bit selects output polarity
// R17: Flags hold until read, events never lost; events arriving while I_CE is low are not captured
// R18: Read-only writes ignored; diag reserved bits 11:9 take writes and read back
module pisr_regs (
  input  wire logic                  I_SYS_CLK,
  input  wire logic                  I_RESET,
  input  wire logic                  I_CE,
  input  wire logic [4:0]            I_REG_ADDR,
  input  wire logic                  I_REG_WR,
  input  wire logic                  I_REG_RD,
  input  wire logic [15:0]           I_REG_WDATA,
  input  wire pisr_pkg::pisr_events_t I_EVENTS,
  input  wire pisr_pkg::pisr_diag_t  I_DIAG,
  input  wire pisr_pkg::pisr_phy_t   I_PHY,
  output logic [15:0]                O_REG_RDATA,
  output logic                       O_DIAG_START,
  output logic                       O_ISOLATE,
  output logic                       O_INT
);
  import pisr_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [4:0]  flags;
  logic [7:0]  int_en;
  logic        diag_en;
  logic [2:0]  diag_rsv;
  logic        isolate;
  logic        int_lvl;
  logic [15:0] ctl2_rest;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] want);
    hit = (a == want);
  endfunction

  wire        wr_int   = I_CE && I_REG_WR && hit(I_REG_ADDR, `PISR_ADDR_INT_CS);
  wire        wr_diag  = I_CE && I_REG_WR && hit(I_REG_ADDR, `PISR_ADDR_DIAG_CS);
  wire        wr_phy   = I_CE && I_REG_WR && hit(I_REG_ADDR, `PISR_ADDR_PHY_CS);
  wire        wr_ctl2  = I_CE && I_REG_WR && hit(I_REG_ADDR, `PISR_ADDR_PHY_CTL2);
  wire        rd_int   = I_CE && I_REG_RD && hit(I_REG_ADDR, `PISR_ADDR_INT_CS);
  wire [4:0]  ev_vec   = I_EVENTS;
  // R17 set beats read clear
  wire [4:0]  next_flags = (rd_int ? 5'h00 : flags) | ev_vec;
  // R6 self clear on completion
  wire        next_diag_en = wr_diag ? (I_REG_WDATA[`PISR_DIAG_EN_BIT] | (diag_en & ~I_DIAG.done))
                                     : (diag_en & ~I_DIAG.done);
  wire        diag_start = wr_diag && I_REG_WDATA[`PISR_DIAG_EN_BIT] && !diag_en;
  // R15 enables gate flags
  wire        int_any  = |(next_flags & int_en[4:0]);

  wire [15:0] rd_int_w  = {int_en, 3'h0, flags};
  // R7 R8 R9 results straight from the measurement
  wire [15:0] rd_diag_w = {diag_en, I_DIAG.result, I_DIAG.short_cable, diag_rsv,
                           I_DIAG.fault_dist};
  // R10 R11 R12 R14 live status, R18 reserved read zero
  wire [15:0] rd_phy_w  = {6'h00, I_PHY.pause_cap, I_PHY.link_up, I_PHY.pol_rev, 1'b0,
                           I_PHY.mdix, I_PHY.energy, isolate, I_PHY.op_mode};
  wire [15:0] rd_ctl2_w = {ctl2_rest[15:10], int_lvl, ctl2_rest[8:0]};
  wire [15:0] rd_mux    = hit(I_REG_ADDR, `PISR_ADDR_INT_CS)   ? rd_int_w  :
                          hit(I_REG_ADDR, `PISR_ADDR_DIAG_CS)  ? rd_diag_w :
                          hit(I_REG_ADDR, `PISR_ADDR_PHY_CS)   ? rd_phy_w  :
                          hit(I_REG_ADDR, `PISR_ADDR_PHY_CTL2) ? rd_ctl2_w : 16'h0000;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      flags        <= 5'h00;
      int_en       <= 8'h00;
      diag_en      <= 1'b0;
      diag_rsv     <= `PISR_DIAG_RSV_RST;
      isolate      <= 1'b0;
      int_lvl      <= 1'b0;
      ctl2_rest    <= 16'h0000;
      O_REG_RDATA  <= 16'h0000;
      O_DIAG_START <= 1'b0;
      O_ISOLATE    <= 1'b0;
      O_INT        <= 1'b1;
    end else if (I_CE) begin
      // R1 R2 R3 R4 R5 sticky event flags
      flags        <= next_flags;
      diag_en      <= next_diag_en;
      O_DIAG_START <= diag_start;
      if (I_REG_RD) begin
        O_REG_RDATA <= rd_mux;
      end
      if (wr_int) begin
        int_en <= I_REG_WDATA[15:8];
      end
      if (wr_diag) begin
        diag_rsv <= I_REG_WDATA[11:9];
      end
      // R13 isolate control
      if (wr_phy) begin
        isolate   <= I_REG_WDATA[`PISR_PHY_ISO_BIT];
        O_ISOLATE <= I_REG_WDATA[`PISR_PHY_ISO_BIT];
      end
      if (wr_ctl2) begin
        int_lvl   <= I_REG_WDATA[`PISR_CTL2_INTLVL_BIT];
        ctl2_rest <= I_REG_WDATA & 16'hFDFF;
      end
      // R16 output polarity
      O_INT <= (wr_ctl2 ? I_REG_WDATA[`PISR_CTL2_INTLVL_BIT] : int_lvl) ? int_any : ~int_any;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);

  chk_link_up_flag: assert property (I_CE && I_EVENTS.link_up |=> flags[0]) // R5
    else $error("link-up event lost");
  chk_link_down_flag: assert property (I_CE && I_EVENTS.link_down |=> flags[2]) // R3
    else $error("link-down event lost");
  chk_pd_flag: assert property (I_CE && I_EVENTS.pd_fault |=> flags[4]) // R1
    else $error("parallel detect fault lost");
  chk_ack_flag: assert property (I_CE && I_EVENTS.lp_ack |=> flags[3]) // R2
    else $error("partner ack lost");
  chk_rem_flag: assert property (I_CE && I_EVENTS.rem_fault |=> flags[1]) // R4
    else $error("remote fault lost");
  sequence s_read_int;
    rd_int && (I_EVENTS == 5'h00);
  endsequence
  chk_read_clears: assert property (s_read_int |=> flags == 5'h00) // R17
    else $error("flags not cleared by read");
  chk_diag_done: assert property (I_CE && diag_en && I_DIAG.done && !wr_diag |=> !diag_en) // R6
    else $error("test enable not self-cleared");
  chk_int_level: assert property (I_CE && !wr_ctl2 |=> O_INT == ($past(int_lvl) ?
                                  $past(int_any) : !$past(int_any))) // R16
    else $error("interrupt polarity wrong");
  chk_iso_write: assert property (wr_phy |=> O_ISOLATE == $past(I_REG_WDATA[3])) // R13
    else $error("isolate write not taken");

  // ----------------------------------------
  // Read path checks
  // ----------------------------------------
  sequence s_rd_phy;
    I_CE && I_REG_RD && hit(I_REG_ADDR, `PISR_ADDR_PHY_CS);
  endsequence
  sequence s_rd_diag;
    I_CE && I_REG_RD && hit(I_REG_ADDR, `PISR_ADDR_DIAG_CS);
  endsequence

  // R14 operation code read
  chk_opmode_read: assert property ( // R14
    s_rd_phy |=> O_REG_RDATA[2:0] == $past(I_PHY.op_mode))
    else $error("operation code read wrong");
  // R11 link and energy read
  chk_link_read: assert property ( // R11
    s_rd_phy |=> O_REG_RDATA[8] == $past(I_PHY.link_up) && O_REG_RDATA[4] == $past(I_PHY.energy))
    else $error("link or energy read wrong");
  // R12 polarity and crossover read
  chk_pol_read: assert property ( // R12
    s_rd_phy |=> O_REG_RDATA[7] == $past(I_PHY.pol_rev) && O_REG_RDATA[5] == $past(I_PHY.mdix))
    else $error("polarity or crossover read wrong");
  // R10 pause capability read
  chk_pause_read: assert property ( // R10
    s_rd_phy |=> O_REG_RDATA[9] == $past(I_PHY.pause_cap))
    else $error("pause capability read wrong");
  // R18 reserved status bits
  chk_phy_reserved: assert property ( // R18
    s_rd_phy |=> O_REG_RDATA[15:10] == 6'h00 && !O_REG_RDATA[6])
    else $error("reserved status bits not zero");
  // R13 isolate read back
  chk_iso_read: assert property ( // R13
    s_rd_phy ##0 !wr_phy |=> O_REG_RDATA[3] == O_ISOLATE)
    else $error("isolate read back wrong");
  // R8 R9 diagnostic fields read
  chk_diag_read: assert property ( // R8 R9
    s_rd_diag |=> O_REG_RDATA[14:12] == $past({I_DIAG.result, I_DIAG.short_cable})
                  && O_REG_RDATA[8:0] == $past(I_DIAG.fault_dist))
    else $error("diagnostic fields read wrong");

  // ----------------------------------------
  // Control checks
  // ----------------------------------------
  // Start is one cycle unless the enable froze it
  sequence s_start_pulse;
    O_DIAG_START ##1 (!O_DIAG_START || !$past(I_CE));
  endsequence

  // R6 enable holds until done
  chk_diag_hold: assert property ( // R6
    diag_en && !I_DIAG.done |=> diag_en)
    else $error("test enable dropped early");
  // R6 start pulse width
  chk_start_pulse: assert property ( // R6
    diag_start |=> s_start_pulse)
    else $error("start pulse wrong");
  // R17 flags never drop without read
  chk_flags_hold: assert property ( // R17
    !rd_int |=> (flags & $past(flags)) == $past(flags))
    else $error("flag lost without read");
  // R18 flag write ignored
  chk_ro_flags: assert property ( // R18
    wr_int && !rd_int && I_EVENTS == 5'h00 |=> flags == $past(flags))
    else $error("flag changed by write");
  // R17 low enable freezes state
  chk_ce_freeze: assert property ( // R17
    !I_CE |=> $stable(flags) && $stable(O_REG_RDATA) && $stable(O_INT) && $stable(O_ISOLATE))
    else $error("state moved with enable low");
endmodule // pisr_regs

// ---- sim/phy_irq_diag_status_regs_tb_top.sv ----
// Self-checking bench for the status register slice
`timescale 1ns/1ps
`include "pisr_map.svh"
module phy_irq_diag_status_regs_tb_top;
  import pisr_pkg::*;
  logic clk, rst, rd, wr, st, iso_o, irq, lvl, iso, ce;
  logic [4:0] addr, flags, en;
  logic [15:0] wd, rdat, v;
  logic [11:0] dfld;
  logic [3:0] dly;
  logic [2:0] ops [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  pisr_events_t ev;
  pisr_diag_t dg;
  pisr_phy_t ph;
  int n_errors = 0;
  int checks_done = 0;
  logic [31:0] rs = 14666;
  pisr_regs uut (.I_SYS_CLK(clk), .I_RESET(rst), .I_CE(ce), .I_REG_ADDR(addr),
    .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wd), .I_EVENTS(ev), .I_DIAG(dg),
    .I_PHY(ph), .O_REG_RDATA(rdat), .O_DIAG_START(st), .O_ISOLATE(iso_o), .O_INT(irq));
  pisr_diag_eng eng (.i_clk(clk), .i_start(st), .i_delay(dly), .i_fields(dfld), .o_diag(dg));
  function automatic logic [15:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[15:0];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [4:0] a, input logic w, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic finish_test();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
  initial begin
    rst = 1'b1; rd = 1'b0; wr = 1'b0; addr = '0; wd = '0; ev = '0; ph = '0;
    dfld = '0; dly = 4'h3; flags = '0; ce = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    acc(`PISR_ADDR_INT_CS, 1'b0, 16'h0);
    chk(rdat, 16'h0);
    acc(`PISR_ADDR_DIAG_CS, 1'b0, 16'h0);
    chk(rdat, 16'h0);
    acc(5'h00, 1'b0, 16'h0);
    chk(rdat, 16'h0);
    chk(irq, 1'b1);
    for (int i = 0; i < 20; i++) begin
      v = rnd();
      ph <= {v[7:3], ops[i % 5]};
      iso = v[3];
      acc(`PISR_ADDR_PHY_CS, 1'b1, v);
      acc(`PISR_ADDR_PHY_CS, 1'b0, 16'h0);
      chk(rdat, {6'h0, ph[7:5], 1'b0, ph[4:3], iso, ph[2:0]});
      chk(iso_o, iso);
      v = rnd();
      en = v[12:8];
      lvl = v[5];
      acc(`PISR_ADDR_INT_CS, 1'b1, {3'h0, en, v[7:0]});
      acc(`PISR_ADDR_PHY_CTL2, 1'b1, {6'h0, lvl, 9'h0});
      v = rnd();
      @(posedge clk) ev <= v[4:0];
      @(posedge clk) ev <= '0;
      flags = flags | v[4:0];
      repeat (2) @(posedge clk);
      #1 chk(irq, lvl ? |(flags & en) : !(|(flags & en)));
      acc(`PISR_ADDR_INT_CS, 1'b0, 16'h0);
      chk(rdat, {3'h0, en, 3'h0, flags});
      flags = '0;
      v = rnd();
      dfld <= {i[1:0], v[9:0]};
      dly <= 4'h3 + {1'b0, v[14:12]};
      acc(`PISR_ADDR_DIAG_CS, 1'b1, {1'b1, v[14:0]});
      chk(st, 1'b1);
      acc(`PISR_ADDR_DIAG_CS, 1'b0, 16'h0);
      chk(rdat[15], 1'b1);
      for (int k = 0; k < 20 && rdat[15] !== 1'b0; k++) acc(`PISR_ADDR_DIAG_CS, 1'b0, 16'h0);
      chk(rdat, {1'b0, dfld[11:9], v[11:9], dfld[8:0]});
    end
    // Write with enable low must not land
    @(posedge clk) ce <= 1'b0;
    acc(`PISR_ADDR_PHY_CS, 1'b1, {12'h0, !iso, 3'h0});
    @(posedge clk) ce <= 1'b1;
    chk(iso_o, iso);
    acc(`PISR_ADDR_PHY_CS, 1'b0, 16'h0);
    chk(rdat, {6'h0, ph[7:5], 1'b0, ph[4:3], iso, ph[2:0]});
    // Event in the read cycle survives the clear
    @(posedge clk);
    addr <= `PISR_ADDR_INT_CS;
    rd <= 1'b1;
    ev <= 5'h01;
    @(posedge clk);
    rd <= 1'b0;
    ev <= '0;
    #1 chk(rdat, {3'h0, en, 8'h00});
    acc(`PISR_ADDR_INT_CS, 1'b0, 16'h0);
    chk(rdat, {3'h0, en, 8'h01});
    finish_test();
  end
endmodule // phy_irq_diag_status_regs_tb_top

// ---- sim/pisr_diag_eng.sv ----
// Cable test engine model on the far side of the diag register
`timescale 1ns/1ps
module pisr_diag_eng (
  input  wire logic            i_clk,
  input  wire logic            i_start,
  input  wire logic [3:0]      i_delay,
  input  wire logic [11:0]     i_fields,
  output pisr_pkg::pisr_diag_t o_diag
);
  import pisr_pkg::*;
  int   cnt = 0;
  logic done = 1'b0;
  // done pulse after a test time
  always @(posedge i_clk) begin
    done <= (cnt == 1);
    cnt  <= i_start ? i_delay : (cnt > 0 ? cnt - 1 : 0);
  end
  assign o_diag = {done, i_fields};
endmodule // pisr_diag_eng
